// [rx_events.sv]
// reset control, q-subcode capture and receiver event flags
`timescale 1ns/1ps
module rx_events
   import rx_events_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // power-down pin
   input  wire logic        chip_powerdown_pin,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   // receiver front end
   input  wire logic        ubit_strobe,
   input  wire logic        ubit,
   input  wire subframe_t   subframe,
   input  wire cs_block_t   cs_block,
   input  wire logic        pll_unlock,
   input  wire logic        nonlinear_stream_flag,
   input  wire logic        cd_surround_stream_flag,
   input  wire logic [3:0]  sample_rate_code,
   input  wire logic        channel_select_bit,
   // interrupt masks
   input  wire logic [7:0]  irq0_mask,
   input  wire logic [7:0]  irq1_mask,
   // interrupt pins and outputs to the clock and audio logic
   output logic      [1:0]  irq_pins,
   output logic             xtal_clk_en,
   output logic             pll_clk_en,
   output logic             recovery_init,
   output logic             serial_audio_out_low,
   output logic             timing_reset
);

   // ****************************************
   // power-down pin filter
   // ****************************************
   logic [2:0]   pd_sync_ff;
   logic         pd_active_ff;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pd_sync_ff <= 3'h0;
      end else begin
         pd_sync_ff <= {pd_sync_ff[1:0], chip_powerdown_pin};
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pd_active_ff <= 1'b1;
      end else if (pd_sync_ff[2] == pd_sync_ff[1]) begin
         pd_active_ff <= ~pd_sync_ff[2];
      end
   end

   // ****************************************
   // power down control register
   // ****************************************
   logic [7:0]   pdc_ff;
   logic         soft_init;
   logic         recov_sleep;
   logic         logic_clr;
   logic         wr_ok;
   logic         rd_ok;

   assign soft_init   = pdc_ff[POS_SOFT_INIT];
   assign recov_sleep = pdc_ff[POS_RECOV_SLEEP];
   assign logic_clr   = pd_active_ff | ~soft_init;
   assign wr_ok       = reg_wr & ~pd_active_ff;
   assign rd_ok       = reg_rd & ~pd_active_ff;

   // only control fields are writable, so soft-init never blocks them
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pdc_ff <= PDC_RESET;
      end else if (pd_active_ff) begin
         pdc_ff <= PDC_RESET;
      end else if (wr_ok && reg_addr == OFS_POWER_DOWN_CONTROL) begin
         pdc_ff <= reg_wdata & PDC_WRITE_MASK;
      end
   end

   // ****************************************
   // clock and audio controls
   // ****************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         xtal_clk_en          <= 1'b0;
         pll_clk_en           <= 1'b0;
         recovery_init        <= 1'b1;
         serial_audio_out_low <= 1'b1;
         timing_reset         <= 1'b1;
      end else begin
         xtal_clk_en          <= ~pd_active_ff;
         pll_clk_en           <= ~pd_active_ff & recov_sleep;
         recovery_init        <= pd_active_ff | ~recov_sleep;
         serial_audio_out_low <= logic_clr;
         timing_reset         <= logic_clr;
      end
   end

   // ****************************************
   // q-subcode framing
   // ****************************************
   qstate_t      qstate_ff;
   logic [4:0]   zero_run_ff;
   logic [4:0]   dist_ff;
   logic [6:0]   qcnt_ff;
   logic [Q_BITS-1:0] qshift_ff;
   logic [Q_BITS-1:0] qstore_ff;
   logic [4:0]   nxt_dist;
   logic         q_done;

   assign nxt_dist = dist_ff + 5'h01;
   assign q_done   = ubit_strobe && qstate_ff == Q_COLLECT && nxt_dist == Q_BIT_DIST && qcnt_ff == Q_BITS_LAST;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         qstate_ff   <= Q_HUNT;
         zero_run_ff <= 5'h00;
         dist_ff     <= 5'h00;
         qcnt_ff     <= 7'h00;
         qshift_ff   <= '0;
      end else if (logic_clr) begin
         qstate_ff   <= Q_HUNT;
         zero_run_ff <= 5'h00;
         dist_ff     <= 5'h00;
         qcnt_ff     <= 7'h00;
      end else if (ubit_strobe) begin
         unique case (qstate_ff)
            Q_HUNT: begin
               if (!ubit) begin
                  if (zero_run_ff != SYNC_ZERO_MIN) begin
                     zero_run_ff <= zero_run_ff + 5'h01;
                  end
               end else if (zero_run_ff == SYNC_ZERO_MIN) begin
                  qstate_ff   <= Q_COLLECT;
                  zero_run_ff <= 5'h00;
                  dist_ff     <= 5'h00;
                  qcnt_ff     <= 7'h00;
               end else begin
                  zero_run_ff <= 5'h00;
               end
            end
            Q_COLLECT: begin
               if (nxt_dist == Q_BIT_DIST) begin
                  qshift_ff <= {ubit, qshift_ff[Q_BITS-1:1]};
                  qcnt_ff   <= qcnt_ff + 7'h01;
                  dist_ff   <= nxt_dist;
                  if (q_done) begin
                     qstate_ff <= Q_HUNT;
                  end
               end else if (ubit && nxt_dist >= START_DIST_MIN) begin
                  dist_ff <= 5'h00;
               end else if (nxt_dist >= START_DIST_MAX) begin
                  qstate_ff <= Q_HUNT;
                  dist_ff   <= 5'h00;
               end else begin
                  dist_ff <= nxt_dist;
               end
            end
         endcase
      end
   end

   logic [Q_BITS-1:0] qnew;
   logic              q_differs;

   assign qnew      = {ubit, qshift_ff[Q_BITS-1:1]};
   assign q_differs = q_done && qnew != qstore_ff;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         qstore_ff <= '0;
      end else if (logic_clr) begin
         qstore_ff <= '0;
      end else if (q_done) begin
         qstore_ff <= qnew;
      end
   end

   // ****************************************
   // receiver event flags
   // ****************************************
   status0_t     st0_ff;
   logic [3:0]   rate_ff;
   logic         emph_ff;
   logic         stream_nl_ff;
   logic         stream_cd_ff;
   logic [CS_BITS-1:0] cs_prev_ff;
   logic [7:0]   cs_byte0;
   logic         nxt_emph;
   logic         rd_clear;
   logic         rate_emph_set;
   logic         cs_set;
   logic         par_set;

   assign rd_clear = rd_ok && reg_addr == OFS_RX_STATUS0;
   assign cs_byte0 = channel_select_bit ? cs_block.byte0_ch2 : cs_block.byte0_ch1;
   assign nxt_emph = cs_block.strobe ? (cs_byte0[CS_PRO_POS] ? cs_byte0[4:2] == EMPH_PRO
                                                             : cs_byte0[5:3] == EMPH_CONSUMER)
                                     : emph_ff;
   assign rate_emph_set = sample_rate_code != rate_ff || nxt_emph != emph_ff;
   assign cs_set   = cs_block.strobe && cs_block.bits != cs_prev_ff;
   assign par_set  = subframe.strobe && (subframe.parity_err || subframe.biphase_err);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rate_ff      <= 4'h0;
         emph_ff      <= 1'b0;
         stream_nl_ff <= 1'b0;
         stream_cd_ff <= 1'b0;
         cs_prev_ff   <= '0;
      end else if (logic_clr) begin
         rate_ff      <= 4'h0;
         emph_ff      <= 1'b0;
         stream_nl_ff <= 1'b0;
         stream_cd_ff <= 1'b0;
         cs_prev_ff   <= '0;
      end else begin
         rate_ff      <= sample_rate_code;
         emph_ff      <= nxt_emph;
         stream_nl_ff <= nonlinear_stream_flag;
         stream_cd_ff <= cd_surround_stream_flag;
         if (cs_block.strobe) begin
            cs_prev_ff <= cs_block.bits;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st0_ff <= '0;
      end else if (logic_clr) begin
         st0_ff <= '0;
      end else begin
         st0_ff.lock_loss  <= pll_unlock;
         st0_ff.compressed <= nonlinear_stream_flag | cd_surround_stream_flag;
         if (subframe.strobe) begin
            st0_ff.validity <= subframe.validity;
         end
         if (cs_block.strobe) begin
            st0_ff.nonaudio <= cs_byte0[CS_AUDIO_POS];
         end
         // set wins over the clear of the same read
         st0_ff.check_err        <= par_set | (st0_ff.check_err & ~rd_clear);
         st0_ff.rate_emph_change <= rate_emph_set | (st0_ff.rate_emph_change & ~rd_clear);
         st0_ff.cstatus_change   <= cs_set | (st0_ff.cstatus_change & ~rd_clear);
         st0_ff.subcode_change   <= q_differs | (st0_ff.subcode_change & ~rd_clear);
      end
   end

   // ****************************************
   // interrupt pins
   // ****************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_pins <= 2'h0;
      end else if (logic_clr) begin
         irq_pins <= 2'h0;
      end else begin
         irq_pins[0] <= |(st0_ff & ~irq0_mask);
         irq_pins[1] <= |(st0_ff & ~irq1_mask);
      end
   end

   // ****************************************
   // register read
   // ****************************************
   logic [7:0]   rd_mux;
   logic [4:0]   sub_idx;

   assign sub_idx = reg_addr - OFS_SUBCODE_FIRST;

   always_comb begin
      rd_mux = 8'h00;
      if (reg_addr == OFS_POWER_DOWN_CONTROL) begin
         rd_mux = pdc_ff;
      end else if (reg_addr == OFS_RX_STATUS0) begin
         rd_mux = st0_ff;
      end else if (reg_addr == OFS_RX_STATUS1) begin
         rd_mux = {1'b0, stream_cd_ff, stream_nl_ff, emph_ff, rate_ff};
      end else if (reg_addr >= OFS_SUBCODE_FIRST && reg_addr <= OFS_SUBCODE_LAST) begin
         rd_mux = qstore_ff[sub_idx*8 +: 8];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= rd_ok;
         if (rd_ok) begin
            reg_rdata <= rd_mux;
         end
      end
   end

endmodule : rx_events

// [rx_events_chk.sv]
// concurrent checks on the ports of the receiver reset, subcode and event block
`timescale 1ns/1ps
module rx_events_chk
   import rx_events_pkg::*;
(
   // clock and reset
   input wire logic       clock,
   input wire logic       resetn,
   // watched inputs
   input wire logic       chip_powerdown_pin,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       pll_unlock,
   input wire logic [7:0] irq0_mask,
   input wire logic [7:0] irq1_mask,
   // watched outputs
   input wire logic       reg_rvalid,
   input wire logic [1:0] irq_pins,
   input wire logic       xtal_clk_en,
   input wire logic       pll_clk_en,
   input wire logic       serial_audio_out_low,
   input wire logic       timing_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic pdc_wr;
   // control write taken while the part is awake
   assign pdc_wr = reg_wr && reg_addr == OFS_POWER_DOWN_CONTROL && xtal_clk_en;

   chk_read_cause: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read answer without a read request");
   chk_pd_quiet: assert property (!chip_powerdown_pin [*7] |-> !reg_rvalid && !xtal_clk_en
      && !pll_clk_en && timing_reset && serial_audio_out_low) else $error("power down pin low but part still active");
   chk_mask0_quiet: assert property ((&irq0_mask) [*2] |-> !irq_pins[0])
      else $error("first interrupt pin high with all events masked");
   chk_mask1_quiet: assert property ($past(&irq1_mask) && (&irq1_mask) |-> !irq_pins[1])
      else $error("second interrupt pin high with all events masked");
   chk_unlock_irq: assert property ((pll_unlock && !irq1_mask[7] && !timing_reset) [*3]
      |-> irq_pins[1]) else $error("unmasked lock loss did not raise the second interrupt pin");
   chk_soft_init: assert property (pdc_wr && !reg_wdata[POS_SOFT_INIT] |-> ##2
      serial_audio_out_low && timing_reset && xtal_clk_en) else $error("soft init did not hold timing and audio");
   chk_sleep_clocks: assert property (pdc_wr && reg_wdata[1:0] == 2'b01 |-> ##2
      !pll_clk_en && xtal_clk_en && !timing_reset) else $error("recovery sleep clocks wrong");
   chk_init_release: assert property (pdc_wr && reg_wdata[1:0] == 2'b11 |-> ##2
      !timing_reset && !serial_audio_out_low && pll_clk_en) else $error("normal mode not resumed");
endmodule : rx_events_chk

bind rx_events rx_events_chk i_chk (.clock, .resetn, .chip_powerdown_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .pll_unlock, .irq0_mask, .irq1_mask, .reg_rvalid, .irq_pins, .xtal_clk_en, .pll_clk_en, .serial_audio_out_low,
   .timing_reset);

// [rx_events_pkg.sv]
// constants and types for the receiver reset, subcode and event block
package rx_events_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [4:0] OFS_POWER_DOWN_CONTROL = 5'h00;
   localparam logic [4:0] OFS_RX_STATUS0         = 5'h05;
   localparam logic [4:0] OFS_RX_STATUS1         = 5'h06;
   localparam logic [4:0] OFS_SUBCODE_FIRST      = 5'h11;
   localparam logic [4:0] OFS_SUBCODE_LAST       = 5'h1a;

   // ****************************************
   // power down control fields and reset value
   // ****************************************
   localparam int          POS_SOFT_INIT   = 0;
   localparam int          POS_RECOV_SLEEP = 1;
   localparam int          POS_XTAL_LO     = 2;
   localparam int          POS_XTAL_HI     = 3;
   localparam int          POS_EXT_CLOCK   = 4;
   localparam logic [7:0] PDC_WRITE_MASK  = 8'h1f;
   localparam logic [7:0] PDC_RESET       = 8'h03;

   // ****************************************
   // subcode framing
   // ****************************************
   localparam logic [4:0] SYNC_ZERO_MIN   = 5'h10;
   localparam logic [4:0] START_DIST_MIN  = 5'h08;
   localparam logic [4:0] START_DIST_MAX  = 5'h10;
   localparam logic [4:0] Q_BIT_DIST      = 5'h01;
   localparam int          Q_BITS          = 80;
   localparam logic [6:0] Q_BITS_LAST     = 7'h4f;
   localparam int          SUBCODE_BYTES   = 10;

   // ****************************************
   // channel status fields
   // ****************************************
   localparam int          CS_PRO_POS      = 0;
   localparam int          CS_AUDIO_POS    = 1;
   localparam logic [2:0] EMPH_CONSUMER   = 3'h1;
   localparam logic [2:0] EMPH_PRO        = 3'h3;
   localparam int          CS_BITS         = 40;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic {
      Q_HUNT    = 1'b0,
      Q_COLLECT = 1'b1
   } qstate_t;

   // receiver status 0, msb first as it reads
   typedef struct packed {
      logic lock_loss;
      logic check_err;
      logic compressed;
      logic validity;
      logic nonaudio;
      logic rate_emph_change;
      logic cstatus_change;
      logic subcode_change;
   } status0_t;

   // one decoded sub-frame from the receiver front end
   typedef struct packed {
      logic strobe;
      logic parity_err;
      logic biphase_err;
      logic validity;
   } subframe_t;

   // one channel status block
   typedef struct packed {
      logic                strobe;
      logic [CS_BITS-1:0] bits;
      logic [7:0]          byte0_ch1;
      logic [7:0]          byte0_ch2;
   } cs_block_t;

endpackage : rx_events_pkg

// [subcode_source.sv]
// model of the source that sends cd user bits carrying one q-subcode frame
`timescale 1ns/1ps
module subcode_source
   import rx_events_pkg::*;
(
   // clock
   input wire logic        clock,
   // command from the bench
   input wire logic        go,
   input wire logic [79:0] q,
   input wire logic [4:0]  gap,
   // user bit stream and busy flag
   output logic            ubit_strobe,
   output logic            ubit,
   output logic            busy
);
   task automatic send_bit(input logic b);
      @(negedge clock);
      ubit_strobe = 1'b1;
      ubit = b;
      @(negedge clock);
      ubit_strobe = 1'b0;
      ubit = ~b;
   endtask : send_bit

   initial begin
      ubit_strobe = 1'b0;
      ubit = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clock iff go);
         busy = 1'b1;
         for (int i = 0; i < 16; i++) send_bit(1'b0);
         for (int s = 0; s < Q_BITS; s++) begin
            send_bit(1'b1);
            send_bit(q[79-s]);
            for (int z = 2; z < gap; z++) send_bit(1'b0);
         end
         busy = 1'b0;
      end
   end
endmodule : subcode_source

// [test_rx_events.sv]
// self-checking testbench for the receiver reset, subcode and event block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin error_cnt++; $display("Error %s expected %h seen %h", nm, ex, gt); end end
module test_rx_events
   import rx_events_pkg::*;
;
   localparam logic [79:0] QA = 80'h0123456789abcdef5a3c;
   localparam logic [79:0] QB = 80'hfedcba9876543210a5c3;
   localparam logic [3:0]  SF [4] = '{4'hc, 4'ha, 4'h9, 4'h8};
   localparam logic [7:0]  S1 [4] = '{8'h40, 8'h40, 8'h10, 8'h00};
   localparam logic [7:0]  S2 [4] = '{8'h00, 8'h00, 8'h10, 8'h00};
   logic        clock = 1'b0, resetn = 1'b0, chip_powerdown_pin = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
   logic [4:0]  reg_addr = 5'h00, gap = 5'h10;
   logic [7:0]  reg_wdata = 8'h00, irq0_mask = 8'hff, irq1_mask = 8'hff, reg_rdata;
   logic        pll_unlock = 1'b0, nonlinear_stream_flag = 1'b0, cd_surround_stream_flag = 1'b0;
   logic        channel_select_bit = 1'b0;
   logic        recovery_init;
   logic [3:0]  sample_rate_code = 4'h0;
   logic [79:0] q = '0;
   logic [1:0]  irq_pins;
   logic        reg_rvalid, ubit_strobe, ubit, busy, xtal_clk_en, pll_clk_en, serial_audio_out_low, timing_reset;
   subframe_t   subframe = '0;
   cs_block_t   cs_block = '0;
   int          error_cnt = 0, checks = 0;

   rx_events i_dut (.clock, .resetn, .chip_powerdown_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .ubit_strobe, .ubit, .subframe, .cs_block, .pll_unlock, .nonlinear_stream_flag,
      .cd_surround_stream_flag, .sample_rate_code, .channel_select_bit, .irq0_mask, .irq1_mask, .irq_pins,
      .xtal_clk_en, .pll_clk_en, .recovery_init, .serial_audio_out_low, .timing_reset);
   subcode_source i_src (.clock, .go, .q, .gap, .ubit_strobe, .ubit, .busy);

   always #5 clock = ~clock;

   task automatic complete_run;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic rd(input logic [4:0] a, input logic [7:0] ex, input string nm);
      string vn;
      vn = {nm, " valid"};
      @(negedge clock);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clock);
      reg_rd = 1'b0;
      `CHK(vn, 1'b1, reg_rvalid)
      `CHK(nm, ex, reg_rdata)
   endtask : rd

   task automatic wr(input logic [7:0] d);
      @(negedge clock);
      reg_wr = 1'b1;
      reg_addr = OFS_POWER_DOWN_CONTROL;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 1'b0;
      @(negedge clock);
   endtask : wr

   task automatic frame(input logic [79:0] v, input logic [4:0] g, input logic [7:0] ex);
      int n;
      @(negedge clock);
      q = v;
      gap = g;
      go = 1'b1;
      @(negedge clock);
      go = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 4000) begin
         @(negedge clock);
         n++;
      end
      `CHK("frame sent", 1'b1, n < 4000)
      rd(OFS_RX_STATUS0, ex, "subcode change");
   endtask : frame

   task automatic subcode(input logic [79:0] v);
      logic [7:0] b;
      for (int k = 0; k < SUBCODE_BYTES; k++) begin
         for (int j = 0; j < 8; j++) b[j] = v[79-8*k-j];
         rd(OFS_SUBCODE_FIRST + 5'(k), b, "subcode byte");
      end
   endtask : subcode

   initial begin
      #400000;
      error_cnt++;
      complete_run();
   end

   initial begin
      repeat (4) @(negedge clock);
      resetn = 1'b1;
      chip_powerdown_pin = 1'b1;
      repeat (8) @(negedge clock);
      rd(OFS_POWER_DOWN_CONTROL, 8'h03, "control reset");
      rd(5'h1f, 8'h00, "unmapped");
      wr(8'hff);
      rd(OFS_POWER_DOWN_CONTROL, 8'h1f, "control write");
      wr(8'h03);
      rd(OFS_RX_STATUS0, 8'h00, "status idle");
      frame(QA, 5'd16, 8'h01);
      subcode(QA);
      rd(OFS_RX_STATUS0, 8'h00, "subcode clear");
      frame(QB, 5'd8, 8'h01);
      frame(QB, 5'd16, 8'h00);
      frame(QA, 5'd17, 8'h00);
      subcode(QB);
      for (int e = 0; e < 4; e++) begin
         @(negedge clock);
         subframe = SF[e];
         @(negedge clock);
         subframe = '0;
         rd(OFS_RX_STATUS0, S1[e], "sub-frame flags");
         rd(OFS_RX_STATUS0, S2[e], "sub-frame flags again");
      end
      for (int f = 1; f < 4; f++) begin
         @(negedge clock);
         {cd_surround_stream_flag, nonlinear_stream_flag} = 2'(f);
         rd(OFS_RX_STATUS0, 8'h20, "compressed");
         rd(OFS_RX_STATUS1, {1'b0, 2'(f), 5'h00}, "stream flags");
      end
      @(negedge clock);
      {cd_surround_stream_flag, nonlinear_stream_flag} = 2'b00;
      sample_rate_code = 4'h2;
      rd(OFS_RX_STATUS0, 8'h04, "rate change");
      rd(OFS_RX_STATUS1, 8'h02, "rate code");
      fork
         rd(OFS_RX_STATUS0, 8'h00, "read during change");
         begin
            @(negedge clock);
            sample_rate_code = 4'h3;
         end
      join
      rd(OFS_RX_STATUS0, 8'h04, "pending change");
      rd(OFS_RX_STATUS0, 8'h00, "change cleared");
      @(negedge clock);
      cs_block = {1'b1, 40'h1, 8'h0a, 8'h00};
      @(negedge clock);
      cs_block = '0;
      rd(OFS_RX_STATUS0, 8'h0e, "channel status flags");
      rd(OFS_RX_STATUS1, 8'h13, "emphasis");
      rd(OFS_RX_STATUS0, 8'h08, "nonaudio level");
      @(negedge clock);
      channel_select_bit = 1'b1;
      cs_block = {1'b1, 40'h1, 8'h0a, 8'h00};
      @(negedge clock);
      cs_block = '0;
      rd(OFS_RX_STATUS0, 8'h04, "second channel");
      @(negedge clock);
      irq0_mask = 8'hbf;
      irq1_mask = 8'h7f;
      pll_unlock = 1'b1;
      repeat (3) @(negedge clock);
      `CHK("irq pins", 2'b10, irq_pins)
      rd(OFS_RX_STATUS0, 8'h80, "lock loss");
      pll_unlock = 1'b0;
      irq0_mask = 8'hff;
      irq1_mask = 8'hff;
      wr(8'h01);
      `CHK("recovered clocks", 1'b0, pll_clk_en)
      `CHK("crystal clocks", 1'b1, xtal_clk_en)
      `CHK("recovery init", 1'b1, recovery_init)
      rd(OFS_POWER_DOWN_CONTROL, 8'h01, "sleep control");
      subcode(QB);
      wr(8'h03);
      `CHK("recovery running", 1'b0, recovery_init)
      wr(8'h02);
      `CHK("audio low", 1'b1, serial_audio_out_low)
      `CHK("clocks in init", 1'b1, xtal_clk_en)
      `CHK("timing reset", 1'b1, timing_reset)
      rd(OFS_SUBCODE_FIRST, 8'h00, "init subcode");
      rd(OFS_POWER_DOWN_CONTROL, 8'h02, "init control");
      wr(8'h03);
      chip_powerdown_pin = 1'b0;
      repeat (8) @(negedge clock);
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      `CHK("read in power down", 1'b0, reg_rvalid)
      wr(8'h00);
      `CHK("clocks stopped", 1'b0, xtal_clk_en)
      chip_powerdown_pin = 1'b1;
      repeat (8) @(negedge clock);
      rd(OFS_POWER_DOWN_CONTROL, 8'h03, "control after power down");
      complete_run();
   end
endmodule : test_rx_events
